// ### logic/fw_loader_pkg.sv
// constants shared by the firmware download register block and its buffer
// assumes the register access engine presents one 16-bit register per beat
package fw_loader_pkg;

    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [15:0] ADDR_RESET_CMD = 16'hF000;
    localparam logic [15:0] ADDR_PROGRESS = 16'hFF70;
    localparam logic [15:0] ADDR_OUTCOME = 16'hFF71;
    localparam logic [15:0] ADDR_TARGET = 16'hFF72;
    localparam logic [15:0] ADDR_LEN_HI = 16'hFF73;
    localparam logic [15:0] ADDR_LEN_LO = 16'hFF74;
    localparam logic [15:0] ADDR_CHECKSUM = 16'hFF75;
    localparam logic [15:0] ADDR_BLK_TOTAL = 16'hFF76;
    localparam logic [15:0] ADDR_BLK_INDEX = 16'hFF77;
    localparam logic [15:0] ADDR_BLK_LEN = 16'hFF78;
    localparam logic [15:0] ADDR_PAY_FIRST = 16'hFF79;
    localparam logic [15:0] ADDR_PAY_LAST = 16'hFFF1;
    localparam logic [15:0] ADDR_LOADER_LO = 16'hFF70;

    // ****************************************
    // field layout and limits
    // ****************************************
    localparam int PAY_WORDS = 121;
    localparam logic [15:0] MAX_BLOCK_BYTES = 16'h00F2;
    localparam logic [15:0] MAX_INSTANCE = 16'h000F;
    localparam logic [7:0] KIND_REBOOT = 8'h00;
    localparam int KIND_LSB = 8;

    // ****************************************
    // exception codes and reset values
    // ****************************************
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [15:0] NOT_AVAILABLE_VALUE = 16'hFFFF;
    localparam logic [15:0] CRC_SEED = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [15:0] {
        WAIT_INFO,
        WAIT_BLOCK,
        WRITE_BLOCK,
        CHECK_FILE,
        WAIT_REBOOT
    } progress_e;

    typedef enum logic [15:0] {
        RES_OK,
        RES_BAD_INFO,
        RES_BAD_BLOCK,
        RES_WRITE_FAIL,
        RES_CRC_FAIL
    } outcome_e;

endpackage

// ### logic/byte_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes a single clock shared with the register block
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;
    wire logic [AW:0] used = wrPtr_q - rdPtr_q;
    wire logic doPush = inValid && inReady;
    wire logic doPop = outValid && outReady;

    assign inReady = used != (AW+1)'(DEPTH);
    assign outValid = used != '0;
    assign outData = mem[rdPtr_q[AW-1:0]];

    always_ff @(posedge core_clk)
    begin
        if (doPush)
        begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end
        else
        begin
            wrPtr_q <= wrPtr_q + (AW+1)'(doPush);
            rdPtr_q <= rdPtr_q + (AW+1)'(doPop);
        end
    end
endmodule
`default_nettype wire

// ### logic/fw_download_regs.sv
// firmware download register block of the boot loader
// assumes one register per request beat, framed by reqFirst/reqLast, same clock
//
// Contract
// - loader registers exist only while loaderActive is high.
// - reset command sits at the normal-mode reset command address.
// - outcome reads as enumeration: ok, info, block, write, crc error.
// - block length above 242 is rejected as an invalid block.
// - payload is byte packed, only the announced bytes are used.
// - writes to read-only status registers answer exception 02.
// - file length accessed as one two-register unit; high half last or low half first in a frame raises an exception.
// - undefined addresses read not-available, writes dropped silently.
`timescale 1ns/1ns
`default_nettype none
module fw_download_regs
    import fw_loader_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic loaderActive,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqFirst,
    input wire logic reqLast,
    input wire logic [15:0] reqAddr,
    input wire logic [15:0] reqWdata,
    output logic rspValid_q,
    output logic [15:0] rspRdata_q,
    output logic [7:0] rspExc_q,
    output logic rebootPulse_q,
    output logic [15:0] resetCmd_q,
    output logic wrValid_q,
    output logic [7:0] wrData_q,
    input wire logic wrReady,
    input wire logic wrFail
);
    // ****************************************
    // decode
    // ****************************************
    progress_e state_q;
    outcome_e result_q;
    logic [15:0] target_q;
    logic [31:0] fileLen_q;
    logic [15:0] lenHi_q;
    logic [15:0] checksum_q;
    logic [15:0] blkTotal_q;
    logic [15:0] blkIndex_q;
    logic [15:0] blkLen_q;
    logic [15:0] payload [PAY_WORDS];
    logic [15:0] nextBlk_q;
    logic [31:0] byteCount_q;
    logic [15:0] crc_q;
    logic [7:0] bytePtr_q;
    logic lenSeen_q;
    logic infoDone_q;
    logic frameEnd_q;

    wire logic inLoader = reqAddr >= ADDR_LOADER_LO && loaderActive;
    wire logic hitReset = reqAddr == ADDR_RESET_CMD;
    wire logic hitStatus = inLoader && (reqAddr == ADDR_PROGRESS || reqAddr == ADDR_OUTCOME);
    wire logic hitPay = inLoader && reqAddr >= ADDR_PAY_FIRST && reqAddr <= ADDR_PAY_LAST;
    wire logic [6:0] payIdx = 7'(reqAddr - ADDR_PAY_FIRST);
    wire logic [7:0] kind = resetKind(reqWdata);
    wire logic badPair = inLoader && ((reqAddr == ADDR_LEN_HI && reqLast) || (reqAddr == ADDR_LEN_LO && reqFirst));
    wire logic badKind = hitReset && reqWrite && loaderActive && kind != KIND_REBOOT;
    wire logic roWrite = hitStatus && reqWrite;
    wire logic [7:0] exc = (roWrite || badPair) ? EXC_ILLEGAL_ADDR : (badKind ? EXC_ILLEGAL_VALUE : EXC_NONE);
    wire logic doWrite = reqValid && reqWrite && exc == EXC_NONE;
    wire logic wrTarget = doWrite && inLoader && reqAddr == ADDR_TARGET;
    wire logic wrTotal = doWrite && inLoader && reqAddr == ADDR_BLK_TOTAL;
    wire logic wrBlkLen = doWrite && inLoader && reqAddr == ADDR_BLK_LEN;
    wire logic frameEnd = reqValid && reqLast;

    // ****************************************
    // read mux
    // ****************************************
    logic [15:0] rdata;
    always_comb
    begin
        rdata = NOT_AVAILABLE_VALUE;
        if (hitReset)
            rdata = resetCmd_q;
        else if (hitPay)
            rdata = payload[payIdx];
        else if (inLoader)
        begin
            unique case (reqAddr)
                ADDR_PROGRESS: rdata = state_q;
                ADDR_OUTCOME: rdata = result_q;
                ADDR_TARGET: rdata = target_q;
                ADDR_LEN_HI: rdata = fileLen_q[31:16];
                ADDR_LEN_LO: rdata = fileLen_q[15:0];
                ADDR_CHECKSUM: rdata = checksum_q;
                ADDR_BLK_TOTAL: rdata = blkTotal_q;
                ADDR_BLK_INDEX: rdata = blkIndex_q;
                ADDR_BLK_LEN: rdata = blkLen_q;
                default: rdata = NOT_AVAILABLE_VALUE;
            endcase
        end
    end

    function automatic logic [7:0] resetKind(input logic [15:0] w);
        resetKind = w[KIND_LSB +: 8];
    endfunction

    function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++)
            r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        crcByte = r;
    endfunction

    // ****************************************
    // stream into the fifo
    // ****************************************
    logic fifoInReady;
    logic fifoOutValid;
    logic [7:0] fifoOutData;
    wire logic [15:0] curWord = payload[bytePtr_q[7:1]];
    // big-endian byte order, only announced bytes
    wire logic [7:0] curByte = bytePtr_q[0] ? curWord[7:0] : curWord[15:8];
    wire logic pushing = state_q == WRITE_BLOCK && 16'(bytePtr_q) < blkLen_q;
    wire logic push = pushing && fifoInReady;
    wire logic outTake = !wrValid_q || wrReady;
    wire logic blockOk = blkLen_q <= MAX_BLOCK_BYTES && blkIndex_q == nextBlk_q;
    wire logic infoOk = target_q <= MAX_INSTANCE && blkTotal_q != ZERO_WORD;

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .inValid(pushing),
        .inReady(fifoInReady),
        .inData(curByte),
        .outValid(fifoOutValid),
        .outReady(outTake),
        .outData(fifoOutData)
    );

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (doWrite && hitPay)
            payload[payIdx] <= reqWdata;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            rspValid_q <= 1'b0;
            rspRdata_q <= ZERO_WORD;
            rspExc_q <= EXC_NONE;
            rebootPulse_q <= 1'b0;
            resetCmd_q <= ZERO_WORD;
            wrValid_q <= 1'b0;
            wrData_q <= 8'h00;
        end
        else
        begin
            rspValid_q <= reqValid;
            rspRdata_q <= reqWrite ? ZERO_WORD : rdata;
            rspExc_q <= reqValid ? exc : EXC_NONE;
            rebootPulse_q <= doWrite && hitReset;
            if (doWrite && hitReset)
                resetCmd_q <= reqWdata;
            if (outTake)
            begin
                wrValid_q <= fifoOutValid;
                wrData_q <= fifoOutData;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            target_q <= ZERO_WORD;
            fileLen_q <= '0;
            lenHi_q <= ZERO_WORD;
            checksum_q <= ZERO_WORD;
            blkTotal_q <= ZERO_WORD;
            blkIndex_q <= ZERO_WORD;
            blkLen_q <= ZERO_WORD;
        end
        else if (doWrite && inLoader)
        begin
            unique case (reqAddr)
                ADDR_TARGET: target_q <= reqWdata;
                ADDR_LEN_HI: lenHi_q <= reqWdata;
                ADDR_LEN_LO: fileLen_q <= {lenHi_q, reqWdata};
                ADDR_CHECKSUM: checksum_q <= reqWdata;
                ADDR_BLK_TOTAL: blkTotal_q <= reqWdata;
                ADDR_BLK_INDEX: blkIndex_q <= reqWdata;
                ADDR_BLK_LEN: blkLen_q <= reqWdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // progress machine
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || !loaderActive)
        begin
            state_q <= WAIT_INFO;
            result_q <= RES_OK;
            nextBlk_q <= ZERO_WORD;
            byteCount_q <= '0;
            crc_q <= CRC_SEED;
            bytePtr_q <= 8'h00;
            lenSeen_q <= 1'b0;
            infoDone_q <= 1'b0;
            frameEnd_q <= 1'b0;
        end
        else
        begin
            // new record clears the latched code
            if (wrTarget)
            begin
                result_q <= RES_OK;
                state_q <= WAIT_INFO;
                infoDone_q <= 1'b0;
            end
            // frame end acted on a cycle late so the frame's last write has landed
            frameEnd_q <= frameEnd;
            if (push)
            begin
                bytePtr_q <= bytePtr_q + 8'h01;
                crc_q <= crcByte(crc_q, curByte);
                byteCount_q <= byteCount_q + 32'h1;
            end
            unique case (state_q)
                WAIT_INFO:
                    if (frameEnd_q && infoDone_q && !wrTarget)
                    begin
                        infoDone_q <= 1'b0;
                        nextBlk_q <= ZERO_WORD;
                        byteCount_q <= '0;
                        crc_q <= CRC_SEED;
                        if (infoOk)
                            state_q <= WAIT_BLOCK;
                        else
                            result_q <= RES_BAD_INFO;
                    end
                WAIT_BLOCK:
                    if (frameEnd_q && lenSeen_q)
                    begin
                        lenSeen_q <= 1'b0;
                        bytePtr_q <= 8'h00;
                        if (blockOk)
                            state_q <= WRITE_BLOCK;
                        else
                        begin
                            result_q <= RES_BAD_BLOCK;
                            state_q <= WAIT_INFO;
                        end
                    end
                WRITE_BLOCK:
                    if (!pushing)
                    begin
                        nextBlk_q <= nextBlk_q + 16'h1;
                        state_q <= (nextBlk_q + 16'h1 == blkTotal_q) ? CHECK_FILE : WAIT_BLOCK;
                    end
                CHECK_FILE:
                    // drain first so a late write failure is still seen
                    if (!fifoOutValid && !wrValid_q)
                    begin
                        if (crc_q == checksum_q && byteCount_q == fileLen_q)
                            state_q <= WAIT_REBOOT;
                        else
                        begin
                            result_q <= RES_CRC_FAIL;
                            state_q <= WAIT_INFO;
                        end
                    end
                WAIT_REBOOT: ;
            endcase
            // a set in the cycle of the frame-end clear must win
            if (wrTotal)
                infoDone_q <= 1'b1;
            if (wrBlkLen)
                lenSeen_q <= 1'b1;
            if (wrFail && (state_q == WRITE_BLOCK || state_q == CHECK_FILE))
            begin
                result_q <= RES_WRITE_FAIL;
                state_q <= WAIT_INFO;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/fw_download_regs_props.sv
// port assertions for the firmware download register block
// assumes it is bound onto fw_download_regs and that everything runs on one clock
`timescale 1ns/1ns
`default_nettype none
module fw_download_regs_props
    import fw_loader_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic loaderActive,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqFirst,
    input wire logic reqLast,
    input wire logic [15:0] reqAddr,
    input wire logic [15:0] reqWdata,
    input wire logic rspValid_q,
    input wire logic [15:0] rspRdata_q,
    input wire logic [7:0] rspExc_q,
    input wire logic rebootPulse_q,
    input wire logic [15:0] resetCmd_q,
    input wire logic wrValid_q,
    input wire logic [7:0] wrData_q,
    input wire logic wrReady
);
    // ****
    // request decode
    // ****
    wire logic rdReq = reqValid && !reqWrite;
    wire logic wrReq = reqValid && reqWrite;
    wire logic cmdWr = wrReq && reqAddr == ADDR_RESET_CMD;
    // outside the loader any kind is taken
    wire logic kindOk = !loaderActive || reqWdata[15:8] == KIND_REBOOT;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    status_ro_write_a:
        assert property (wrReq && loaderActive && (reqAddr == ADDR_PROGRESS || reqAddr == ADDR_OUTCOME)
            |=> rspExc_q == EXC_ILLEGAL_ADDR) else $error("status write not refused");
    reserved_read_a:
        assert property (rdReq && reqAddr > ADDR_PAY_LAST
            |=> rspRdata_q == NOT_AVAILABLE_VALUE && rspExc_q == EXC_NONE) else $error("reserved read wrong");
    reserved_write_a:
        assert property (wrReq && reqAddr > ADDR_PAY_LAST |=> rspValid_q && rspExc_q == EXC_NONE)
            else $error("reserved write raised exception");
    loader_hidden_a:
        assert property (rdReq && !loaderActive && reqAddr >= ADDR_LOADER_LO
            |=> rspRdata_q == NOT_AVAILABLE_VALUE) else $error("loader register visible");
    kind_refused_a:
        assert property (cmdWr && !kindOk |=> rspExc_q == EXC_ILLEGAL_VALUE && !rebootPulse_q)
            else $error("non reboot kind accepted");
    reboot_taken_a:
        assert property (cmdWr && kindOk |=> rebootPulse_q && resetCmd_q == $past(reqWdata))
            else $error("reset command not taken");
    reboot_cause_a:
        assert property (rebootPulse_q |-> $past(cmdWr)) else $error("reboot without command");
    split_length_a:
        assert property (reqValid && loaderActive
            && (reqAddr == ADDR_LEN_LO && reqFirst || reqAddr == ADDR_LEN_HI && reqLast)
            |=> rspExc_q == EXC_ILLEGAL_ADDR) else $error("partial length accepted");
    byte_hold_a:
        assert property (wrValid_q && !wrReady |=> wrValid_q && $stable(wrData_q))
            else $error("payload byte dropped");
endmodule
bind fw_download_regs fw_download_regs_props u_props (.core_clk(core_clk), .rst_b(rst_b),
    .loaderActive(loaderActive), .reqValid(reqValid), .reqWrite(reqWrite), .reqFirst(reqFirst),
    .reqLast(reqLast), .reqAddr(reqAddr), .reqWdata(reqWdata), .rspValid_q(rspValid_q),
    .rspRdata_q(rspRdata_q), .rspExc_q(rspExc_q), .rebootPulse_q(rebootPulse_q),
    .resetCmd_q(resetCmd_q), .wrValid_q(wrValid_q), .wrData_q(wrData_q), .wrReady(wrReady));
`default_nettype wire

// ### tb/flash_writer_model.sv
// behavioural flash writer taking the payload byte stream
// assumes the bench commands stalls and failures at clock edges
`timescale 1ns/1ns
`default_nettype none
module flash_writer_model (
    input wire logic core_clk,
    input wire logic wrValid,
    input wire logic [7:0] wrData,
    input wire logic stall,
    input wire logic failReq,
    output logic wrReady,
    output logic wrFail,
    output int count
);
    logic [7:0] gotByte [0:511];
    logic failQ = 1'b0;
    int n = 0;
    assign wrReady = !stall;
    assign wrFail = failQ;
    assign count = n;
    always @(posedge core_clk)
    begin
        if (wrValid && wrReady)
        begin
            gotByte[n[8:0]] <= wrData;
            n <= n + 1;
        end
        failQ <= failReq && wrValid && wrReady;
    end
endmodule
`default_nettype wire

// ### tb/fw_download_regs_tb.sv
// self-checking bench for the firmware download register block
// assumes the flash writer model and the checker are compiled with it
`timescale 1ns/1ns
`default_nettype none
module fw_download_regs_tb
    import fw_loader_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic loaderActive = 1'b1;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic reqFirst = 1'b0;
    logic reqLast = 1'b0;
    logic [15:0] reqAddr = 16'h0000;
    logic [15:0] reqWdata = 16'h0000;
    logic stall = 1'b0;
    logic failReq = 1'b0;
    logic rspValid_q, rebootPulse_q, wrValid_q, wrReady, wrFail;
    logic [15:0] rspRdata_q, resetCmd_q;
    logic [7:0] rspExc_q, wrData_q;
    logic [7:0] fileByte [0:255];
    logic [15:0] frame [0:127];
    int n_mismatch = 0;
    int total_checks = 0;
    int gotCount;
    always #2 core_clk = ~core_clk;
    fw_download_regs #(.DEPTH(FIFO_DEPTH)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .loaderActive(loaderActive), .reqValid(reqValid), .reqWrite(reqWrite), .reqFirst(reqFirst),
        .reqLast(reqLast), .reqAddr(reqAddr), .reqWdata(reqWdata), .rspValid_q(rspValid_q),
        .rspRdata_q(rspRdata_q), .rspExc_q(rspExc_q), .rebootPulse_q(rebootPulse_q),
        .resetCmd_q(resetCmd_q), .wrValid_q(wrValid_q), .wrData_q(wrData_q), .wrReady(wrReady),
        .wrFail(wrFail));
    flash_writer_model u_writer (.core_clk(core_clk), .wrValid(wrValid_q), .wrData(wrData_q),
        .stall(stall), .failReq(failReq), .wrReady(wrReady), .wrFail(wrFail), .count(gotCount));
    // ****
    // access tasks
    // ****
    task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] gotv);
        total_checks++;
        if (gotv !== expv)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, expv, gotv);
        end
    endtask
    // one beat; the answer is sampled once the following edge has landed
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic f, input logic l);
        @(posedge core_clk);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqAddr <= a;
        reqWdata <= d;
        reqFirst <= f;
        reqLast <= l;
        @(posedge core_clk);
        reqValid <= 1'b0;
        #1;
        chk("rsp valid", 16'h0001, {15'h0000, rspValid_q});
    endtask
    task automatic wfr(input logic [15:0] a0, input int n);
        for (int i = 0; i < n; i++)
            acc(1'b1, a0 + 16'(i), frame[i], i == 0, i == n - 1);
    endtask
    task automatic rdo(input logic [15:0] expv);
        acc(1'b0, ADDR_OUTCOME, 16'h0000, 1'b1, 1'b1);
        chk("outcome", expv, rspRdata_q);
    endtask
    task automatic waitState(input logic [15:0] expv);
        int k;
        k = 0;
        acc(1'b0, ADDR_PROGRESS, 16'h0000, 1'b1, 1'b1);
        while (rspRdata_q !== expv && k < 300)
        begin
            acc(1'b0, ADDR_PROGRESS, 16'h0000, 1'b1, 1'b1);
            k++;
        end
        chk("progress", expv, rspRdata_q);
    endtask
    task automatic info(input logic [15:0] tgt, input logic [15:0] crc, input logic [31:0] len);
        frame[0] = tgt;
        frame[1] = len[31:16];
        frame[2] = len[15:0];
        frame[3] = crc;
        frame[4] = 16'h0001;
        wfr(ADDR_TARGET, 5);
    endtask
    task automatic blk(input logic [15:0] idx, input logic [15:0] len, input int nw);
        frame[0] = idx;
        frame[1] = len;
        for (int i = 0; i < nw; i++)
            frame[2 + i] = {fileByte[2 * i], fileByte[2 * i + 1]};
        wfr(ADDR_BLK_INDEX, 2 + nw);
    endtask
    // msb-first ccitt over the file bytes
    function automatic logic [15:0] crc16(input int n);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < n; i++)
        begin
            c = c ^ {fileByte[i], 8'h00};
            for (int b = 0; b < 8; b++)
                c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
        end
        return c;
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****
    // tests
    // ****
    initial
    begin
        int base;
        for (int i = 0; i < 256; i++)
            fileByte[i] = 8'(i * 7 + 3);
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        waitState(WAIT_INFO);
        rdo(RES_OK);
        acc(1'b1, ADDR_PROGRESS, 16'h0001, 1'b1, 1'b1);
        chk("ro exc", EXC_ILLEGAL_ADDR, rspExc_q);
        acc(1'b1, ADDR_OUTCOME, 16'h0001, 1'b1, 1'b1);
        chk("ro exc", EXC_ILLEGAL_ADDR, rspExc_q);
        acc(1'b0, 16'hFFF5, 16'h0000, 1'b1, 1'b1);
        chk("reserved rd", NOT_AVAILABLE_VALUE, rspRdata_q);
        acc(1'b1, 16'hFFF5, 16'h1234, 1'b1, 1'b1);
        chk("reserved exc", EXC_NONE, rspExc_q);
        acc(1'b1, ADDR_LEN_LO, 16'h0004, 1'b1, 1'b1);
        chk("split exc", EXC_ILLEGAL_ADDR, rspExc_q);
        acc(1'b0, ADDR_LEN_HI, 16'h0000, 1'b1, 1'b1);
        chk("split exc", EXC_ILLEGAL_ADDR, rspExc_q);
        $display("test status done");
        acc(1'b1, ADDR_RESET_CMD, 16'h0105, 1'b1, 1'b1);
        chk("kind exc", EXC_ILLEGAL_VALUE, rspExc_q);
        acc(1'b1, ADDR_RESET_CMD, 16'h000F, 1'b1, 1'b1);
        chk("reboot", 16'h0001, {15'h0000, rebootPulse_q});
        chk("reset cmd", 16'h000F, resetCmd_q);
        @(posedge core_clk);
        loaderActive <= 1'b0;
        acc(1'b0, ADDR_PROGRESS, 16'h0000, 1'b1, 1'b1);
        chk("hidden", NOT_AVAILABLE_VALUE, rspRdata_q);
        acc(1'b1, ADDR_RESET_CMD, 16'h0107, 1'b1, 1'b1);
        chk("cmd normal", 16'h0107, resetCmd_q);
        @(posedge core_clk);
        loaderActive <= 1'b1;
        $display("test reset command done");
        info(16'h0010, 16'h0000, 32'd4);
        rdo(RES_BAD_INFO);
        waitState(WAIT_INFO);
        rdo(RES_BAD_INFO);
        info(16'h0003, 16'h0000, 32'd4);
        waitState(WAIT_BLOCK);
        rdo(RES_OK);
        blk(16'h0000, 16'd243, 0);
        rdo(RES_BAD_BLOCK);
        info(16'h0003, 16'h0000, 32'd4);
        waitState(WAIT_BLOCK);
        blk(16'h0001, 16'd4, 2);
        rdo(RES_BAD_BLOCK);
        $display("test rejection done");
        // a stalled writer makes the fifo fill and refuse
        base = gotCount;
        @(posedge core_clk);
        stall <= 1'b1;
        info(16'h0003, crc16(242), 32'd242);
        waitState(WAIT_BLOCK);
        blk(16'h0000, 16'd242, 121);
        repeat (50) @(posedge core_clk);
        #1 chk("stall hold", 16'h0001, {15'h0000, wrValid_q});
        @(posedge core_clk);
        stall <= 1'b0;
        waitState(WAIT_REBOOT);
        rdo(RES_OK);
        chk("byte count", 16'd242, 16'(gotCount - base));
        for (int i = 0; i < 242; i++)
            chk("byte", {8'h00, fileByte[i]}, {8'h00, u_writer.gotByte[base + i]});
        $display("test download done");
        info(16'h0003, crc16(4) ^ 16'h0001, 32'd4);
        waitState(WAIT_BLOCK);
        blk(16'h0000, 16'd4, 2);
        waitState(WAIT_INFO);
        rdo(RES_CRC_FAIL);
        @(posedge core_clk);
        failReq <= 1'b1;
        info(16'h0003, crc16(4), 32'd4);
        waitState(WAIT_BLOCK);
        blk(16'h0000, 16'd4, 2);
        waitState(WAIT_INFO);
        rdo(RES_WRITE_FAIL);
        $display("test failures done");
        conclude();
    end
    initial
    begin
        #200000;
        n_mismatch++;
        $display("watchdog expired");
        conclude();
    end
endmodule
`default_nettype wire
